// [rtl/itd_pkg.sv]
// constants and helper functions shared by the inband tone decode status block
package itd_pkg;
  localparam int FREQ_W = 12;                       // tone frequency width, whole hertz
  localparam logic [7:0] EVENT_STATUS_ADDR = 8'hC6; // event status register
  localparam logic [7:0] TONE_REPORT_ADDR = 8'hCC;  // tone report register
  localparam int INBAND_FLAG_BIT = 13;              // inband tone change flag
  localparam int DTMF_FLAG_BIT = 12;                // dtmf on/off flag
  localparam int SELCALL_BIT = 15;                  // report: selcall tone present
  localparam int DTMF_BIT = 10;                     // report: dtmf tone present
  localparam int CODE_LSB = 11;                     // report: code field low bit
  localparam logic [15:0] REG_RESET = 16'h0000;     // value of both registers after reset
  localparam logic [11:0] MATCH_TOL = 12'h00A;      // accepted frequency error in hertz
  localparam logic [11:0] NO_TONE = 12'h000;        // table entry that never matches
  localparam logic [3:0] REPEAT_CODE = 4'hE;        // usual repeat tone, reported as is

  // default table, entry 15 first so that index n holds code n
  localparam logic [15:0][11:0] DEFAULT_TABLE = {
    12'h41F, 12'h83E, 12'h3DF, 12'h8C7, 12'h3A2, 12'h960, 12'h744, 12'h6D3,
    12'h668, 12'h604, 12'h5A6, 12'h54E, 12'h4FB, 12'h4AD, 12'h464, 12'h7BD};

  // dtmf row and column frequencies, index 0 lowest
  localparam logic [3:0][11:0] DTMF_LOW = {12'h3AD, 12'h354, 12'h302, 12'h2B9};
  localparam logic [3:0][11:0] DTMF_HIGH = {12'h661, 12'h5C5, 12'h538, 12'h4B9};

  // keypad row and column to tone code
  function automatic logic [3:0] dtmf_code(input logic [1:0] row, input logic [1:0] col);
    logic [3:0] code;
    code = 4'h0;
    if (col == 2'h3) begin
      code = (row == 2'h3) ? 4'h0 : 4'(4'hD + {2'h0, row});
    end else if (row == 2'h3) begin
      code = (col == 2'h0) ? 4'hB : ((col == 2'h1) ? 4'hA : 4'hC);
    end else begin
      code = 4'(4'h1 + 4'(row * 3) + {2'h0, col});
    end
    return code;
  endfunction : dtmf_code

  // tone code to row (bits 3:2) and column (bits 1:0)
  function automatic logic [3:0] dtmf_pos(input logic [3:0] code);
    logic [3:0] pos;
    pos = 4'h0;
    unique case (code)
      4'h0: pos = 4'hF;
      4'hA: pos = 4'hD;
      4'hB: pos = 4'hC;
      4'hC: pos = 4'hE;
      4'hD, 4'hE, 4'hF: pos = {2'(code - 4'hD), 2'h3};
      default: pos = {2'(4'(code - 4'h1) / 3), 2'(4'(code - 4'h1) % 3)};
    endcase
    return pos;
  endfunction : dtmf_pos
endpackage : itd_pkg

// [rtl/itd_tone_table.sv]
// programmable sixteen entry tone table with first-match lookup
module itd_tone_table import itd_pkg::*; (
  input wire logic core_clk, // main clock
  input wire logic rst, // synchronous reset, active high
  input wire logic progWr, // table write strobe
  input wire logic [3:0] progIdx, // entry to overwrite
  input wire logic [FREQ_W-1:0] progFreq, // new frequency, zero means no tone
  input wire logic [FREQ_W-1:0] candFreq, // candidate frequency to look up
  output logic hit, // some entry matches
  output logic [3:0] hitCode // lowest matching entry
);
  typedef struct packed {
    logic [15:0][FREQ_W-1:0] entry; // tone frequencies
  } itd_table_t;

  itd_table_t s; // registered state
  itd_table_t next_s; // next state
  logic [15:0] match; // per entry match

  // one comparator per entry; a no-tone entry never matches
  for (genvar i = 0; i < 16; i++) begin : g_cmp
    logic [FREQ_W-1:0] diff; // absolute error
    assign diff = (candFreq > s.entry[i]) ? candFreq - s.entry[i] : s.entry[i] - candFreq;
    assign match[i] = (s.entry[i] != NO_TONE) && (diff <= MATCH_TOL);
  end

  // descending scan: walking down lets the lowest index win
  always_comb begin
    hit = |match;
    hitCode = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (match[i]) begin
        hitCode = 4'(i);
      end
    end
  end

  // host overwrites any entry, default set restored by reset
  always_comb begin
    next_s = s;
    if (progWr) begin
      next_s.entry[progIdx] = progFreq;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s.entry <= DEFAULT_TABLE;
    end else begin
      s <= next_s;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_first_match: assert property (hit
    |-> match[hitCode] && ((match & ((16'h0001 << hitCode) - 16'h0001)) == 16'h0000))
    else $error("reported entry is not the first match");
  chk_prog_store: assert property (progWr |=> s.entry[$past(progIdx)] == $past(progFreq))
    else $error("table write not stored");
endmodule : itd_tone_table

// [rtl/itd_tone_status.sv]
// inband and dtmf receive status with tone report, plus dtmf tx tone selection
module itd_tone_status import itd_pkg::*; (
  input wire logic core_clk, // main clock, 250 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic rdEn, // register read strobe
  input wire logic [7:0] rdAddr, // register address
  output logic [15:0] rdData, // read data, registered
  input wire logic progWr, // tone table write strobe
  input wire logic [3:0] progIdx, // tone table entry
  input wire logic [FREQ_W-1:0] progFreq, // tone table frequency
  input wire logic candValid, // inband detector sees a tone
  input wire logic [FREQ_W-1:0] candFreq, // inband candidate frequency
  input wire logic dtmfValid, // dtmf detector sees a pair
  input wire logic [1:0] dtmfRow, // dtmf low tone index
  input wire logic [1:0] dtmfCol, // dtmf high tone index
  input wire logic txDtmfEn, // dtmf generator running
  input wire logic [3:0] txDtmfCode, // dtmf code to send
  input wire logic singleTone, // only one tone per code
  output logic [FREQ_W-1:0] txLowFreq, // low tone to generate, zero for none
  output logic [FREQ_W-1:0] txHighFreq // high tone to generate, zero for none
);
  typedef struct packed {
    logic flagInband; // sticky inband change flag
    logic flagDtmf; // sticky dtmf change flag
    logic [15:0] report; // tone report register
    logic selOn; // inband tone currently valid
    logic [3:0] selCode; // code of that tone
    logic dtmfOn; // dtmf pair currently valid
    logic [15:0] rdData; // read data
    logic [FREQ_W-1:0] txLow; // low tone output
    logic [FREQ_W-1:0] txHigh; // high tone output
  } itd_state_t;

  itd_state_t s; // registered state
  itd_state_t next_s; // next state
  logic hit; // table lookup matched
  logic [3:0] hitCode; // first matching code
  logic selNow; // valid inband tone this cycle
  logic selEvt; // inband on, off or change
  logic dtmfEvt; // dtmf on or off
  logic [3:0] dtmfNowCode; // code of current dtmf pair
  logic [3:0] txPos; // row and column of tx code
  logic stsRead; // status register being read

  itd_tone_table i_itd_tone_table (
    .core_clk(core_clk),
    .rst(rst),
    .progWr(progWr),
    .progIdx(progIdx),
    .progFreq(progFreq),
    .candFreq(candFreq),
    .hit(hit),
    .hitCode(hitCode)
  );

  // a repeat tone is just another code here; no expansion or suppression
  assign selNow = candValid && hit;
  assign selEvt = (selNow != s.selOn) || (selNow && hitCode != s.selCode);
  assign dtmfEvt = dtmfValid != s.dtmfOn;
  assign dtmfNowCode = dtmf_code(dtmfRow, dtmfCol);
  assign txPos = dtmf_pos(txDtmfCode);
  assign stsRead = rdEn && (rdAddr == EVENT_STATUS_ADDR);

  // next state: flags, report, read data and tx tones
  always_comb begin
    next_s = s;
    next_s.selOn = selNow;
    next_s.selCode = selNow ? hitCode : 4'h0;
    next_s.dtmfOn = dtmfValid;
    // reading status clears the flags, but a fresh event in the same cycle wins
    if (stsRead) begin
      next_s.flagInband = 1'b0;
      next_s.flagDtmf = 1'b0;
    end
    if (selEvt) begin
      next_s.flagInband = 1'b1;
    end
    if (dtmfEvt) begin
      next_s.flagDtmf = 1'b1;
    end
    // report only moves on an event, so repeated reads see the same value
    if (selEvt) begin
      if (selNow) begin
        next_s.report = 16'h0000;
        next_s.report[SELCALL_BIT] = 1'b1;
        next_s.report[CODE_LSB +: 4] = hitCode;
      end else begin
        next_s.report = 16'h0000;
      end
    end
    // dtmf is applied last: if both change together the dtmf view is kept,
    // running both detectors at once is not expected anyway
    if (dtmfEvt) begin
      if (dtmfValid) begin
        next_s.report = 16'h0000;
        next_s.report[DTMF_BIT] = 1'b1;
        next_s.report[CODE_LSB +: 4] = dtmfNowCode;
      end else begin
        next_s.report = 16'h0000;
      end
    end
    // register reads; unmapped addresses read zero
    if (rdEn) begin
      next_s.rdData = 16'h0000;
      if (rdAddr == EVENT_STATUS_ADDR) begin
        next_s.rdData[INBAND_FLAG_BIT] = s.flagInband;
        next_s.rdData[DTMF_FLAG_BIT] = s.flagDtmf;
      end else if (rdAddr == TONE_REPORT_ADDR) begin
        next_s.rdData = s.report;
      end
    end
    // tx tone pair; single tone keeps low for 1-7 and 0, high for 8-F
    next_s.txLow = 12'h000;
    next_s.txHigh = 12'h000;
    if (txDtmfEn) begin
      if (!singleTone || txDtmfCode == 4'h0 || txDtmfCode < 4'h8) begin
        next_s.txLow = DTMF_LOW[txPos[3:2]];
      end
      if (!singleTone || txDtmfCode >= 4'h8) begin
        next_s.txHigh = DTMF_HIGH[txPos[1:0]];
      end
    end
  end

  // single state register; reset clears flags and report
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
      s.report <= REG_RESET;
      s.rdData <= REG_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign rdData = s.rdData;
  assign txLowFreq = s.txLow;
  assign txHighFreq = s.txHigh;

  // assertions share one clock and are held off while reset is asserted
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // an event must always leave its flag set, even against a status read
  chk_inband_flag_set: assert property (selEvt |=> s.flagInband)
    else $error("inband event did not set flag");
  chk_dtmf_flag_set: assert property (dtmfEvt |=> s.flagDtmf)
    else $error("dtmf event did not set flag");
  // flags are sticky: only an event or a status read may move them
  chk_inband_flag_hold: assert property (!stsRead && !selEvt
    |=> $stable(s.flagInband))
    else $error("inband flag moved without event or read");
  chk_dtmf_flag_hold: assert property (!stsRead && !dtmfEvt
    |=> $stable(s.flagDtmf))
    else $error("dtmf flag moved without event or read");
  // a status read returns the flags and clears them in the same step
  chk_flag_read: assert property (stsRead && s.flagInband && !selEvt
    |=> s.rdData[INBAND_FLAG_BIT] && !s.flagInband)
    else $error("status read did not return and clear flag");
  chk_dtmf_read: assert property (stsRead && s.flagDtmf && !dtmfEvt
    |=> s.rdData[DTMF_FLAG_BIT] && !s.flagDtmf)
    else $error("status read did not return and clear dtmf flag");
  // selcall report carries the type bit and the code, nothing else
  chk_sel_report: assert property (selEvt && selNow && !dtmfEvt
    |=> s.report == (16'h8000 | {1'b0, $past(hitCode), 11'h000}))
    else $error("selcall report wrong");
  // the repeat code is reported like any other code
  chk_repeat_code: assert property (selEvt && selNow && !dtmfEvt
    && hitCode == REPEAT_CODE |=> s.report[CODE_LSB +: 4] == REPEAT_CODE)
    else $error("repeat tone not reported as its code");
  chk_off_clear: assert property (selEvt && !selNow && !dtmfEvt
    |=> s.report == 16'h0000)
    else $error("report not cleared at tone end");
  chk_dtmf_report: assert property (dtmfEvt && dtmfValid
    |=> s.report[DTMF_BIT] && s.report[14:11] == $past(dtmfNowCode))
    else $error("dtmf report wrong");
  chk_dtmf_clear: assert property (dtmfEvt && !dtmfValid |=> s.report == 16'h0000)
    else $error("report not cleared at dtmf end");
  // report and read data only move on their own events
  chk_report_hold: assert property (!selEvt && !dtmfEvt |=> $stable(s.report))
    else $error("report moved without an event");
  chk_report_read: assert property (rdEn && rdAddr == TONE_REPORT_ADDR
    |=> s.rdData == $past(s.report))
    else $error("report read returned a different value");
  chk_rd_hold: assert property (!rdEn |=> $stable(s.rdData))
    else $error("read data moved without a read");
  // keypad decode spot checks, middle and two corners of the grid
  chk_key_five: assert property (dtmfValid && dtmfRow == 2'h1 && dtmfCol == 2'h1
    |-> dtmfNowCode == 4'h5)
    else $error("dtmf code mapping wrong");
  chk_key_d: assert property (dtmfValid && dtmfRow == 2'h3 && dtmfCol == 2'h3
    |-> dtmfNowCode == 4'h0)
    else $error("dtmf corner key mapping wrong");
  chk_key_star: assert property (dtmfValid && dtmfRow == 2'h3 && dtmfCol == 2'h0
    |-> dtmfNowCode == 4'hB)
    else $error("dtmf star key mapping wrong");
  // tx gives two tones normally, one in single tone mode, silence when off
  chk_single_tone: assert property (txDtmfEn && singleTone
    |=> (s.txLow == 12'h000) != (s.txHigh == 12'h000))
    else $error("single tone mode gave two or no tones");
  chk_dual_tone: assert property (txDtmfEn && !singleTone
    |=> s.txLow != 12'h000 && s.txHigh != 12'h000)
    else $error("dual tone mode lost a tone");
  chk_tx_silent: assert property (!txDtmfEn
    |=> s.txLow == 12'h000 && s.txHigh == 12'h000)
    else $error("tone output while generator off");
  chk_key_d_tx: assert property (txDtmfEn && singleTone && txDtmfCode == 4'h0
    |=> s.txLow == DTMF_LOW[3] && s.txHigh == 12'h000)
    else $error("single tone for code zero wrong");
endmodule : itd_tone_status

// [tb/itd_host_model.sv]
// host side model: register reads and tone table writes for the status block
module itd_host_model import itd_pkg::*; (
  input wire logic core_clk, // main clock
  output logic rdEn, // read strobe
  output logic [7:0] rdAddr, // read address
  input wire logic [15:0] rdData, // read data
  output logic progWr, // table write strobe
  output logic [3:0] progIdx, // table entry
  output logic [FREQ_W-1:0] progFreq // table frequency
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial begin
    rdEn = 1'b0;
    rdAddr = 8'h00;
    progWr = 1'b0;
    progIdx = 4'h0;
    progFreq = 12'h000;
  end

  // one strobe cycle; the address is then parked on its inverse so a stale
  // address cannot pass for a held one, and data is taken once it has settled
  task automatic read(input logic [7:0] addr, output logic [15:0] data);
    @(negedge core_clk);
    rdEn = 1'b1;
    rdAddr = addr;
    @(negedge core_clk);
    rdEn = 1'b0;
    rdAddr = ~addr;
    @(negedge core_clk);
    data = rdData;
  endtask : read

  // overwrite one table entry; zero frequency marks an entry with no tone
  task automatic prog(input logic [3:0] idx, input logic [FREQ_W-1:0] freq);
    @(negedge core_clk);
    progWr = 1'b1;
    progIdx = idx;
    progFreq = freq;
    @(negedge core_clk);
    progWr = 1'b0;
    progFreq = ~freq;
  endtask : prog
endmodule : itd_host_model

// [tb/itd_tone_status_test.sv]
// self-checking bench for the inband tone decode status block
module itd_tone_status_test import itd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst, rdEn, progWr, candValid, dtmfValid, txDtmfEn, singleTone; // stimulus
  logic [7:0] rdAddr; // read address from the host
  logic [15:0] rdData; // read data
  logic [3:0] progIdx, txDtmfCode; // table entry, tx code
  logic [1:0] dtmfRow, dtmfCol; // dtmf pair indices
  logic [11:0] progFreq, candFreq, txLowFreq, txHighFreq; // frequencies
  int error_cnt = 0; // mismatches
  int checks = 0; // comparisons
  // default selcall frequencies by code, keypad codes by row and column
  logic [11:0] sel [16] = '{12'h7BD, 12'h464, 12'h4AD, 12'h4FB, 12'h54E, 12'h5A6, 12'h604,
    12'h668, 12'h6D3, 12'h744, 12'h960, 12'h3A2, 12'h8C7, 12'h3DF, 12'h83E, 12'h41F};
  logic [3:0] key [16] = '{4'h1, 4'h2, 4'h3, 4'hD, 4'h4, 4'h5, 4'h6, 4'hE,
    4'h7, 4'h8, 4'h9, 4'hF, 4'hB, 4'hA, 4'hC, 4'h0};
  logic [11:0] lo [4] = '{12'h2B9, 12'h302, 12'h354, 12'h3AD}; // row tones
  logic [11:0] hi [4] = '{12'h4B9, 12'h538, 12'h5C5, 12'h661}; // column tones

  itd_tone_status i_itd_tone_status (.core_clk(core_clk), .rst(rst), .rdEn(rdEn),
    .rdAddr(rdAddr), .rdData(rdData), .progWr(progWr), .progIdx(progIdx),
    .progFreq(progFreq), .candValid(candValid), .candFreq(candFreq), .dtmfValid(dtmfValid),
    .dtmfRow(dtmfRow), .dtmfCol(dtmfCol), .txDtmfEn(txDtmfEn), .txDtmfCode(txDtmfCode),
    .singleTone(singleTone), .txLowFreq(txLowFreq), .txHighFreq(txHighFreq));
  itd_host_model i_itd_host_model (.core_clk(core_clk), .rdEn(rdEn), .rdAddr(rdAddr),
    .rdData(rdData), .progWr(progWr), .progIdx(progIdx), .progFreq(progFreq));

  // 250 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    i_itd_host_model.read(a, d);
    cmp(d, exp);
  endtask : rd

  // change the inband detector, then read status (clearing it) and the report
  task automatic tone(input logic v, input logic [11:0] f, input logic [15:0] rep);
    @(negedge core_clk);
    candValid = v;
    candFreq = f;
    repeat (2) @(negedge core_clk);
    rd(EVENT_STATUS_ADDR, 16'h2000);
    rd(TONE_REPORT_ADDR, rep);
  endtask : tone

  task automatic dtmf(input logic v, input logic [3:0] k, input logic [15:0] rep);
    @(negedge core_clk);
    dtmfValid = v;
    {dtmfRow, dtmfCol} = k;
    repeat (2) @(negedge core_clk);
    rd(EVENT_STATUS_ADDR, 16'h1000);
    rd(TONE_REPORT_ADDR, rep);
  endtask : dtmf

  task automatic end_of_test();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  // hang guard, far beyond the length of the main sequence
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    $display("ERROR at %0t: run did not finish in time", $time);
    end_of_test();
  end

  // main sequence; the two detectors are never active together
  initial begin
    rst = 1'b1;
    {candFreq, txDtmfCode, dtmfRow, dtmfCol} = '0;
    {candValid, dtmfValid, txDtmfEn, singleTone} = 4'h0;
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    rd(EVENT_STATUS_ADDR, 16'h0000);
    rd(TONE_REPORT_ADDR, 16'h0000);
    rd(8'h00, 16'h0000);
    for (int n = 0; n < 16; n++) begin
      tone(1'b1, sel[n], 16'h8000 | (16'(n) << 11));
      tone(1'b0, sel[n], 16'h0000);
    end
    // three, repeat, three: each step is a change of tone
    tone(1'b1, 12'h4FB, 16'h9800);
    rd(TONE_REPORT_ADDR, 16'h9800);
    tone(1'b1, 12'h83E, 16'hF000);
    tone(1'b1, 12'h4FB, 16'h9800);
    tone(1'b0, 12'h4FB, 16'h0000);
    i_itd_host_model.prog(4'h2, 12'h4FB);
    tone(1'b1, 12'h4FB, 16'h9000);
    tone(1'b0, 12'h4FB, 16'h0000);
    i_itd_host_model.prog(4'hF, NO_TONE);
    @(negedge core_clk);
    candValid = 1'b1;
    candFreq = 12'h41F;
    repeat (2) @(negedge core_clk);
    rd(EVENT_STATUS_ADDR, 16'h0000);
    rd(TONE_REPORT_ADDR, 16'h0000);
    candValid = 1'b0;
    for (int k = 0; k < 16; k++) begin
      dtmf(1'b1, 4'(k), 16'h0400 | (16'(key[k]) << 11));
      dtmf(1'b0, 4'(k), 16'h0000);
    end
    txDtmfEn = 1'b1;
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 16; k++) begin
        @(negedge core_clk);
        singleTone = s[0];
        txDtmfCode = key[k];
        repeat (2) @(negedge core_clk);
        cmp({4'h0, txLowFreq}, (s == 1 && key[k] > 4'h7) ? 16'h0 : {4'h0, lo[k / 4]});
        cmp({4'h0, txHighFreq}, (s == 1 && key[k] < 4'h8) ? 16'h0 : {4'h0, hi[k % 4]});
      end
    end
    end_of_test();
  end
endmodule : itd_tone_status_test
